// ===== ocf_pkg.sv
// Constants, carriers and register map of the counter overflow flag bank
//
// Contract
// - Receive flags A hold receive packet wraps of ports 0..3 in bits 0, 2, 4, 6; bits 1, 3, 5 read 0.
// - Receive flags A hold receive packet wraps of port 4 in bit 7 and port 5 in bit 8.
// - Receive flags A hold receive octet wraps of ports 0..3 in bits 9, 11, 13, 15; 10, 12, 14 read 0.
// - Receive flags B hold receive octet wraps of port 4 in bit 0, port 5 in bit 1; 15:2 read 0.
// - Transmit flags A hold transmit packet wraps of ports 0..3 in bits 0, 2, 4, 6; 1, 3, 5 read 0.
// - Transmit flags A hold transmit packet wraps of port 4 in bit 7 and port 5 in bit 8.
// - Transmit flags A hold transmit octet wraps of ports 0..3 in bits 9, 11, 13, 15; rest read 0.
// - Transmit flags B hold transmit octet wraps of port 4 in bit 0, port 5 in bit 1; 15:2 read 0.
// - A flag reads 1 once its counter has overflowed and 0 while it has not; a read clears the flags it returned unless a new wrap lands on its access edge.
// - Receive flags A sit at index 114h, transmit flags A at 116h, both resetting to zero.
// - Each watched counter is 32 bits wide and a flag marks a wrap of the full 32-bit value.
package ocf_pkg;

  localparam int unsigned OCF_DATA_W    = 32;
  localparam int unsigned OCF_FLAG_W    = 16;
  localparam int unsigned OCF_IDX_W     = 10;
  localparam int unsigned OCF_COUNTER_W = 32;
  localparam int unsigned OCF_IRQ_W     = 4;

  // Register indices; byte address is four times the index
  localparam logic [OCF_IDX_W-1:0] OCF_IDX_RX_A     = 10'h114;
  localparam logic [OCF_IDX_W-1:0] OCF_IDX_RX_B     = 10'h115;
  localparam logic [OCF_IDX_W-1:0] OCF_IDX_TX_A     = 10'h116;
  localparam logic [OCF_IDX_W-1:0] OCF_IDX_TX_B     = 10'h117;
  localparam logic [OCF_IDX_W-1:0] OCF_IDX_IRQ_STAT = 10'h120;
  localparam logic [OCF_IDX_W-1:0] OCF_IDX_IRQ_MASK = 10'h121;

  localparam logic [OCF_FLAG_W-1:0] OCF_FLAG_RESET = 16'h0000;
  localparam logic [OCF_IRQ_W-1:0]  OCF_IRQ_RESET  = 4'h0;

  // Field positions in the A registers
  localparam int unsigned OCF_POS_P0_PKT = 0;
  localparam int unsigned OCF_POS_P1_PKT = 2;
  localparam int unsigned OCF_POS_P2_PKT = 4;
  localparam int unsigned OCF_POS_P3_PKT = 6;
  localparam int unsigned OCF_POS_P4_PKT = 7;
  localparam int unsigned OCF_POS_P5_PKT = 8;
  localparam int unsigned OCF_POS_P0_OCT = 9;
  localparam int unsigned OCF_POS_P1_OCT = 11;
  localparam int unsigned OCF_POS_P2_OCT = 13;
  localparam int unsigned OCF_POS_P3_OCT = 15;
  // Field positions in the B registers
  localparam int unsigned OCF_POS_P4_OCT = 0;
  localparam int unsigned OCF_POS_P5_OCT = 1;

  // Implemented bits; reserved bits stay zero
  localparam logic [OCF_FLAG_W-1:0] OCF_VALID_A = 16'habd5;
  localparam logic [OCF_FLAG_W-1:0] OCF_VALID_B = 16'h0003;

  // Interrupt status and mask bit positions
  localparam int unsigned OCF_IRQ_RX_A = 0;
  localparam int unsigned OCF_IRQ_RX_B = 1;
  localparam int unsigned OCF_IRQ_TX_A = 2;
  localparam int unsigned OCF_IRQ_TX_B = 3;

  // One-cycle wrap pulses of one direction, one per 32-bit counter
  typedef struct packed {
    logic port_zero_packet_wrap;
    logic port_one_packet_wrap;
    logic port_two_packet_wrap;
    logic port_three_packet_wrap;
    logic port_four_packet_wrap;
    logic port_five_packet_wrap;
    logic port_zero_octet_wrap;
    logic port_one_octet_wrap;
    logic port_two_octet_wrap;
    logic port_three_octet_wrap;
    logic port_four_octet_wrap;
    logic port_five_octet_wrap;
  } ocf_wrap_s;

  typedef enum logic [2:0] {
    OCF_SEL_NONE,
    OCF_SEL_RX_A,
    OCF_SEL_RX_B,
    OCF_SEL_TX_A,
    OCF_SEL_TX_B,
    OCF_SEL_STAT,
    OCF_SEL_MASK
  } ocf_sel_e;

endpackage : ocf_pkg

// ===== ocf_flag_reg.sv
// Sticky flag register with snapshot clear
`timescale 1ns/100ps
module ocf_flag_reg #(
  parameter int unsigned     WIDTH = 16,
  parameter logic [WIDTH-1:0] VALID = '1,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] set_vec,
  input  wire logic [WIDTH-1:0] clr_vec,
  output logic      [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  // Set beats clear; only bits already reported are cleared
  always_comb
  begin
    flags_nxt = ((flags_r & ~clr_vec) | set_vec) & VALID;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_r <= RESET;
    else
      flags_r <= flags_nxt;
  end

  assign flags = flags_r;
endmodule : ocf_flag_reg

// ===== ocf_top.sv
// Counter overflow flag bank with APB slave and interrupt
`timescale 1ns/100ps
module ocf_top #(
  parameter int unsigned ADDR_W    = 12,
  parameter int unsigned COUNTER_W = ocf_pkg::OCF_COUNTER_W
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ADDR_W-1:0]           paddr,
  input  wire logic [ocf_pkg::OCF_DATA_W-1:0] pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [ocf_pkg::OCF_DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire ocf_pkg::ocf_wrap_s          rx_wrap,
  input  wire ocf_pkg::ocf_wrap_s          tx_wrap,
  output logic                             irq
);
  import ocf_pkg::*;

  // Wrap pulses come from counters of COUNTER_W bits; one pulse per full rollover
  localparam int unsigned WRAP_COUNTER_BITS = COUNTER_W;

  logic                  setup_ph;
  logic                  access_ph;
  ocf_sel_e              sel;
  logic [OCF_FLAG_W-1:0] set_rx_a;
  logic [OCF_FLAG_W-1:0] set_rx_b;
  logic [OCF_FLAG_W-1:0] set_tx_a;
  logic [OCF_FLAG_W-1:0] set_tx_b;
  logic [OCF_FLAG_W-1:0] clr_rx_a;
  logic [OCF_FLAG_W-1:0] clr_rx_b;
  logic [OCF_FLAG_W-1:0] clr_tx_a;
  logic [OCF_FLAG_W-1:0] clr_tx_b;
  logic [OCF_FLAG_W-1:0] flg_rx_a;
  logic [OCF_FLAG_W-1:0] flg_rx_b;
  logic [OCF_FLAG_W-1:0] flg_tx_a;
  logic [OCF_FLAG_W-1:0] flg_tx_b;
  logic [OCF_IRQ_W-1:0]  stat_set;
  logic [OCF_IRQ_W-1:0]  stat_clr;
  logic [OCF_IRQ_W-1:0]  irq_stat_r;
  logic [OCF_IRQ_W-1:0]  irq_mask_r;
  logic [OCF_FLAG_W-1:0] snap_nxt;
  logic [OCF_FLAG_W-1:0] snap_r;
  logic                  rd_clr_hit;

  // Address decode; misaligned and unknown words map to nothing
  function automatic ocf_sel_e decode(input logic [ADDR_W-1:0] addr);
    logic [OCF_IDX_W-1:0] idx;
    idx = OCF_IDX_W'(addr >> 2);
    if ((addr[1:0] != 2'b00) || ((addr >> 2) > ADDR_W'(idx)))
      decode = OCF_SEL_NONE;
    else if (idx == OCF_IDX_RX_A)
      decode = OCF_SEL_RX_A;
    else if (idx == OCF_IDX_RX_B)
      decode = OCF_SEL_RX_B;
    else if (idx == OCF_IDX_TX_A)
      decode = OCF_SEL_TX_A;
    else if (idx == OCF_IDX_TX_B)
      decode = OCF_SEL_TX_B;
    else if (idx == OCF_IDX_IRQ_STAT)
      decode = OCF_SEL_STAT;
    else if (idx == OCF_IDX_IRQ_MASK)
      decode = OCF_SEL_MASK;
    else
      decode = OCF_SEL_NONE;
  endfunction : decode

  // Places packet and octet wraps of one direction in an A register
  function automatic logic [OCF_FLAG_W-1:0] map_a(input ocf_wrap_s w);
    logic [OCF_FLAG_W-1:0] v;
    v = OCF_FLAG_RESET;
    v[OCF_POS_P0_PKT] = w.port_zero_packet_wrap;
    v[OCF_POS_P1_PKT] = w.port_one_packet_wrap;
    v[OCF_POS_P2_PKT] = w.port_two_packet_wrap;
    v[OCF_POS_P3_PKT] = w.port_three_packet_wrap;
    v[OCF_POS_P4_PKT] = w.port_four_packet_wrap;
    v[OCF_POS_P5_PKT] = w.port_five_packet_wrap;
    v[OCF_POS_P0_OCT] = w.port_zero_octet_wrap;
    v[OCF_POS_P1_OCT] = w.port_one_octet_wrap;
    v[OCF_POS_P2_OCT] = w.port_two_octet_wrap;
    v[OCF_POS_P3_OCT] = w.port_three_octet_wrap;
    map_a = v;
  endfunction : map_a

  // Places port 4 and 5 octet wraps in a B register
  function automatic logic [OCF_FLAG_W-1:0] map_b(input ocf_wrap_s w);
    logic [OCF_FLAG_W-1:0] v;
    v = OCF_FLAG_RESET;
    v[OCF_POS_P4_OCT] = w.port_four_octet_wrap;
    v[OCF_POS_P5_OCT] = w.port_five_octet_wrap;
    map_b = v;
  endfunction : map_b

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign sel       = decode(paddr);

  assign set_rx_a = map_a(rx_wrap);
  assign set_rx_b = map_b(rx_wrap);
  assign set_tx_a = map_a(tx_wrap);
  assign set_tx_b = map_b(tx_wrap);

  // Clear only what the read returned, so a wrap during setup is kept
  assign rd_clr_hit = access_ph & ~pwrite;
  assign clr_rx_a   = (rd_clr_hit && sel == OCF_SEL_RX_A) ? snap_r : '0;
  assign clr_rx_b   = (rd_clr_hit && sel == OCF_SEL_RX_B) ? snap_r : '0;
  assign clr_tx_a   = (rd_clr_hit && sel == OCF_SEL_TX_A) ? snap_r : '0;
  assign clr_tx_b   = (rd_clr_hit && sel == OCF_SEL_TX_B) ? snap_r : '0;

  ocf_flag_reg #(
    .WIDTH (OCF_FLAG_W),
    .VALID (OCF_VALID_A),
    .RESET (OCF_FLAG_RESET)
  ) u_rx_a (
    .pclk    (pclk),
    .presetn (presetn),
    .set_vec (set_rx_a),
    .clr_vec (clr_rx_a),
    .flags   (flg_rx_a)
  );

  ocf_flag_reg #(
    .WIDTH (OCF_FLAG_W),
    .VALID (OCF_VALID_B),
    .RESET (OCF_FLAG_RESET)
  ) u_rx_b (
    .pclk    (pclk),
    .presetn (presetn),
    .set_vec (set_rx_b),
    .clr_vec (clr_rx_b),
    .flags   (flg_rx_b)
  );

  ocf_flag_reg #(
    .WIDTH (OCF_FLAG_W),
    .VALID (OCF_VALID_A),
    .RESET (OCF_FLAG_RESET)
  ) u_tx_a (
    .pclk    (pclk),
    .presetn (presetn),
    .set_vec (set_tx_a),
    .clr_vec (clr_tx_a),
    .flags   (flg_tx_a)
  );

  ocf_flag_reg #(
    .WIDTH (OCF_FLAG_W),
    .VALID (OCF_VALID_B),
    .RESET (OCF_FLAG_RESET)
  ) u_tx_b (
    .pclk    (pclk),
    .presetn (presetn),
    .set_vec (set_tx_b),
    .clr_vec (clr_tx_b),
    .flags   (flg_tx_b)
  );

  // Interrupt events: any new wrap landing in a flag register
  always_comb
  begin
    stat_set               = OCF_IRQ_RESET;
    stat_set[OCF_IRQ_RX_A] = |(set_rx_a & OCF_VALID_A);
    stat_set[OCF_IRQ_RX_B] = |(set_rx_b & OCF_VALID_B);
    stat_set[OCF_IRQ_TX_A] = |(set_tx_a & OCF_VALID_A);
    stat_set[OCF_IRQ_TX_B] = |(set_tx_b & OCF_VALID_B);
  end

  assign stat_clr = (rd_clr_hit && sel == OCF_SEL_STAT) ? snap_r[OCF_IRQ_W-1:0] : '0;

  // Status is sticky, read clears, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_r <= OCF_IRQ_RESET;
    else
      irq_stat_r <= (irq_stat_r & ~stat_clr) | stat_set;
  end

  // Mask lives in byte lane 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_r <= OCF_IRQ_RESET;
    else if (access_ph && pwrite && sel == OCF_SEL_MASK && pstrb[0])
      irq_mask_r <= pwdata[OCF_IRQ_W-1:0];
  end

  // Read value is caught in setup so prdata comes from a flop with no wait state
  always_comb
  begin
    snap_nxt = OCF_FLAG_RESET;
    case (sel)
      OCF_SEL_RX_A: snap_nxt = flg_rx_a;
      OCF_SEL_RX_B: snap_nxt = flg_rx_b;
      OCF_SEL_TX_A: snap_nxt = flg_tx_a;
      OCF_SEL_TX_B: snap_nxt = flg_tx_b;
      OCF_SEL_STAT: snap_nxt = {{(OCF_FLAG_W-OCF_IRQ_W){1'b0}}, irq_stat_r};
      OCF_SEL_MASK: snap_nxt = {{(OCF_FLAG_W-OCF_IRQ_W){1'b0}}, irq_mask_r};
      default:      snap_nxt = OCF_FLAG_RESET;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      snap_r <= OCF_FLAG_RESET;
    else if (setup_ph)
      snap_r <= pwrite ? OCF_FLAG_RESET : snap_nxt;
  end

  assign prdata  = {{(OCF_DATA_W-OCF_FLAG_W){1'b0}}, snap_r};
  assign pready  = 1'b1;
  // Unmapped words answer with an error; writes to flag words are ignored
  assign pslverr = access_ph & (sel == OCF_SEL_NONE);
  assign irq     = |(irq_stat_r & irq_mask_r);

endmodule : ocf_top

// ===== ocf_top_asserts.sv
// Assertion checker for the counter overflow flag bank
`timescale 1ns/100ps
module ocf_top_asserts #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic                            pclk,
  input wire logic                            presetn,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [ADDR_W-1:0]               paddr,
  input wire logic [ocf_pkg::OCF_DATA_W-1:0]  pwdata,
  input wire logic [3:0]                      pstrb,
  input wire logic [ocf_pkg::OCF_DATA_W-1:0]  prdata,
  input wire logic                            pready,
  input wire logic                            pslverr,
  input wire ocf_pkg::ocf_wrap_s              rx_wrap,
  input wire ocf_pkg::ocf_wrap_s              tx_wrap,
  input wire logic                            irq
);
  import ocf_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A wrap seen before the setup edge of a read must be in that read's data
  property p_bit(logic w, logic [11:0] a, int b);
    $past(w) && psel && !penable && !pwrite && paddr == a |=> prdata[b];
  endproperty
  AST_RX_P3_PKT: assert property (p_bit(rx_wrap.port_three_packet_wrap, 12'h450, 6))
    else $error("rx port three packet flag missing");
  AST_RX_P5_PKT: assert property (p_bit(rx_wrap.port_five_packet_wrap, 12'h450, 8))
    else $error("rx port five packet flag missing");
  AST_RX_P3_OCT: assert property (p_bit(rx_wrap.port_three_octet_wrap, 12'h450, 15))
    else $error("rx port three octet flag missing");
  AST_RX_P5_OCT: assert property (p_bit(rx_wrap.port_five_octet_wrap, 12'h454, 1))
    else $error("rx port five octet flag missing");
  AST_TX_P2_PKT: assert property (p_bit(tx_wrap.port_two_packet_wrap, 12'h458, 4))
    else $error("tx port two packet flag missing");
  AST_TX_P4_PKT: assert property (p_bit(tx_wrap.port_four_packet_wrap, 12'h458, 7))
    else $error("tx port four packet flag missing");
  AST_TX_P2_OCT: assert property (p_bit(tx_wrap.port_two_octet_wrap, 12'h458, 13))
    else $error("tx port two octet flag missing");
  AST_TX_P4_OCT: assert property (p_bit(tx_wrap.port_four_octet_wrap, 12'h45c, 0))
    else $error("tx port four octet flag missing");
  AST_RSV_A: assert property (psel && penable && paddr == 12'h450 |->
    (prdata & ~{16'h0000, OCF_VALID_A}) == 32'h0) else $error("reserved bits set");
  AST_RSV_B: assert property (psel && !penable && paddr == 12'h45c ##1 penable
    |-> prdata[31:2] == 30'h0) else $error("reserved bits set");
  AST_RDY: assert property (psel && penable |-> pready)
    else $error("ready low in access");
  COV_RD: cover property (psel && penable && paddr == 12'h450 && prdata[0]);
  COV_IRQ: cover property ($rose(irq));
  COV_ERR: cover property (pslverr);
endmodule : ocf_top_asserts

// ===== tb.sv
// Self-checking testbench of the counter overflow flag bank
`timescale 1ns/100ps
module tb;
  import ocf_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  ocf_wrap_s   rx_wrap, tx_wrap;
  int          miscompares, total_checks, cycles;
  localparam logic [11:0] RXA = {OCF_IDX_RX_A, 2'b00};
  localparam logic [11:0] RXB = {OCF_IDX_RX_B, 2'b00};
  localparam logic [11:0] TXA = {OCF_IDX_TX_A, 2'b00};
  localparam logic [11:0] TXB = {OCF_IDX_TX_B, 2'b00};
  localparam logic [11:0] STA = {OCF_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] MSK = {OCF_IDX_IRQ_MASK, 2'b00};
  ocf_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_wrap(rx_wrap), .tx_wrap(tx_wrap), .irq(irq));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, r);
    chk("mapped error", 32'h0, {31'h0, err});
  endtask : rd_chk
  // Pulse starts at once, so a read started with it sees the wrap before setup
  task automatic wrap(input logic [11:0] rv, input logic [11:0] tv);
    rx_wrap <= ocf_wrap_s'(rv);
    tx_wrap <= ocf_wrap_s'(tv);
    @(posedge pclk);
    rx_wrap <= '0;
    tx_wrap <= '0;
  endtask : wrap
  task automatic t_reset;
    logic [11:0] al[6] = '{RXA, RXB, TXA, TXB, STA, MSK};
    foreach (al[i]) rd_chk("reset value", al[i], 32'h0);
    xfer(1'b0, 12'h400, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, r);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_map;
    int pos[12] = '{0, 2, 4, 6, 7, 8, 9, 11, 13, 15, 0, 1};
    logic [11:0] v;
    logic [31:0] ea, eb;
    for (int i = 0; i < 24; i++)
    begin
      v = 12'h800 >> (i % 12);
      ea = (i % 12) < 10 ? 32'h1 << pos[i % 12] : 32'h0;
      eb = (i % 12) < 10 ? 32'h0 : 32'h1 << pos[i % 12];
      wrap(i < 12 ? v : 12'h0, i < 12 ? 12'h0 : v);
      rd_chk("rx flags a", RXA, i < 12 ? ea : 32'h0);
      rd_chk("rx flags b", RXB, i < 12 ? eb : 32'h0);
      rd_chk("tx flags a", TXA, i < 12 ? 32'h0 : ea);
      rd_chk("tx flags b", TXB, i < 12 ? 32'h0 : eb);
      rd_chk("rx flags a cleared", RXA, 32'h0);
      rd_chk("tx flags a cleared", TXA, 32'h0);
    end
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("t_map done");
  endtask : t_map
  task automatic t_snap;
    // Wrap sampled on the edge that raises psel must be in that read's data
    fork
      wrap(12'h145, 12'h000);
      rd_chk("rx a snapshot", RXA, 32'h8140);
    join
    fork
      wrap(12'h145, 12'h000);
      rd_chk("rx b snapshot", RXB, 32'h2);
    join
    fork
      wrap(12'h000, 12'h28a);
      rd_chk("tx a snapshot", TXA, 32'h2090);
    join
    fork
      wrap(12'h000, 12'h28a);
      rd_chk("tx b snapshot", TXB, 32'h1);
    join
    rd_chk("rx a set again", RXA, 32'h8140);
    rd_chk("tx a set again", TXA, 32'h2090);
    $display("t_snap done");
  endtask : t_snap
  task automatic t_hit;
    wrap(12'h800, 12'h0);
    fork
      xfer(1'b0, RXA, 32'h0);
      begin
        // Wrap lands on the access edge of the clearing read
        repeat (2) @(posedge pclk);
        rx_wrap <= ocf_wrap_s'(12'h800);
        @(posedge pclk);
        rx_wrap <= '0;
      end
    join
    chk("first read", 32'h1, r);
    rd_chk("wrap kept", RXA, 32'h1);
    rd_chk("now clear", RXA, 32'h0);
    $display("t_hit done");
  endtask : t_hit
  task automatic t_irq;
    xfer(1'b0, STA, 32'h0);
    xfer(1'b1, MSK, 32'h1);
    rd_chk("mask", MSK, 32'h1);
    wrap(12'h800, 12'h0);
    @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    xfer(1'b1, RXA, 32'hffff);
    rd_chk("flag write ignored", RXA, 32'h1);
    rd_chk("status", STA, 32'h1);
    @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    xfer(1'b1, MSK, 32'h0);
    wrap(12'h0, 12'h001);
    @(posedge pclk);
    chk("irq masked off", 32'h0, {31'h0, irq});
    rd_chk("status tx b", STA, 32'h8);
    $display("t_irq done");
  endtask : t_irq
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      conclude();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    rx_wrap = '0;
    tx_wrap = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_map();
    t_snap();
    t_hit();
    t_irq();
    conclude();
  end
endmodule : tb
bind ocf_top ocf_top_asserts #(.ADDR_W(ADDR_W)) chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_wrap(rx_wrap), .tx_wrap(tx_wrap), .irq(irq));
